// ### core/fpd_params.svh
`ifndef FPD_PARAMS_SVH
`define FPD_PARAMS_SVH
// times in ns unless named _us / _ms
`define FPD_CLK_PERIOD_NS   10
`define FPD_ROW_ACCESS_NS   80
`define FPD_RANDOM_CYCLE_NS 140
`define FPD_RMW_CYCLE_NS    165
`define FPD_PRECHARGE_NS    50
`define FPD_ROW_HOLD_NS     20
`define FPD_CAS_WIDTH_NS    20
`define FPD_CAS_PRE_NS      10
`define FPD_WE_WIDTH_NS     12
`define FPD_POWERUP_US      200
`define FPD_REFRESH_MS      16.4
`define FPD_REFRESH_ROWS    1024
`define FPD_INIT_REFRESHES  8
// derived cycle counts: minima round up
`define FPD_CYC_MIN(ns) (((ns) + `FPD_CLK_PERIOD_NS - 1) / `FPD_CLK_PERIOD_NS)
`define FPD_ROW_HOLD_CYC    `FPD_CYC_MIN(`FPD_ROW_HOLD_NS)
`define FPD_ACCESS_CYC      (`FPD_CYC_MIN(`FPD_ROW_ACCESS_NS) + 2)
`define FPD_CAS_CYC         `FPD_CYC_MIN(`FPD_CAS_WIDTH_NS)
`define FPD_CAS_PRE_CYC     `FPD_CYC_MIN(`FPD_CAS_PRE_NS)
`define FPD_WE_CYC          `FPD_CYC_MIN(`FPD_WE_WIDTH_NS)
`define FPD_PRE_CYC         `FPD_CYC_MIN(`FPD_PRECHARGE_NS)
`define FPD_RC_CYC          `FPD_CYC_MIN(`FPD_RANDOM_CYCLE_NS)
`define FPD_RMW_CYC         `FPD_CYC_MIN(`FPD_RMW_CYCLE_NS)
`define FPD_POWERUP_CYC     (`FPD_POWERUP_US * 1000 / `FPD_CLK_PERIOD_NS)
// interval rounds down: 1.64 ms / 1024 rows, a tenth of the 16.4 ms period
`define FPD_REFRESH_GAP_CYC (164000 / `FPD_CLK_PERIOD_NS * 10 / `FPD_REFRESH_ROWS)
`endif

// ### core/fpd_pkg.sv
package fpd_pkg;
  typedef enum logic [9:0] {
    FPD_POWERUP = 10'h001,
    FPD_IDLE    = 10'h002,
    FPD_ROW     = 10'h004,
    FPD_COL     = 10'h008,
    FPD_DATA    = 10'h010,
    FPD_WRLATE  = 10'h020,
    FPD_CASUP   = 10'h040,
    FPD_RASUP   = 10'h080,
    FPD_PRE     = 10'h100,
    FPD_REFR    = 10'h200
  } fpd_state_t;
  typedef enum logic [1:0] {
    FPD_OP_READ  = 2'h0,
    FPD_OP_WRITE = 2'h1,
    FPD_OP_RMW   = 2'h2
  } fpd_op_t;
endpackage : fpd_pkg

// ### core/fpd_timer.sv
`timescale 1ns/1ps
// down counter with load; also used as refresh interval timer
module fpd_timer #(
  parameter int WIDTH = 16
) (
  // clock
  input  wire logic             clk_sys,
  input  wire logic             rst_n,
  input  wire logic             clk_en,
  // control
  input  wire logic             load,
  input  wire logic [WIDTH-1:0] load_value,
  // status
  output logic                  done
);
  typedef struct packed {
    logic [WIDTH-1:0] count;
  } fpd_timer_state_t;
  fpd_timer_state_t st, next_st;
  always_comb begin
    next_st = st;
    if (load) begin
      next_st.count = load_value;
    end else if (st.count != '0) begin
      next_st.count = st.count - 1'b1;
    end
  end
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      st <= '0;
    end else if (clk_en) begin
      st <= next_st;
    end
  end
  assign done = (st.count == '0);
endmodule : fpd_timer

// ### core/fpd_ctrl.sv
`timescale 1ns/1ps
`include "fpd_params.svh"
// How it works
// - row address goes out, row strobe falls, then column address, column strobe falls
// - address is driven a cycle before each strobe falls
// - early write drops write first; read-modify-write drops it after column strobe
// - row strobe stays low across accesses to the same open row
// - any column order and any mix of operations inside a page
// - one column strobe per device, decoded from the top request bits
// - one refresh every 161 cycles: 1024 refreshes in about 1.65 ms, well inside 16.4 ms
// - random cycles kept at least the random cycle time apart
// - read-modify-write cycles kept at least the rmw cycle time long
// - 200 us with strobes high, then eight refresh cycles before accesses
module fpd_ctrl
  import fpd_pkg::*;
#(
  parameter int DEVICES      = 2,
  parameter int POWERUP_CYC  = `FPD_POWERUP_CYC,
  parameter int REFRESH_GAP  = `FPD_REFRESH_GAP_CYC
) (
  // clock and reset
  input  wire logic                       clk_sys,
  input  wire logic                       rst_n,
  input  wire logic                       clk_en,
  // user request
  input  wire logic                       req_valid,
  output logic                            req_ready,
  input  wire fpd_pkg::fpd_op_t           req_op,
  input  wire logic [$clog2(DEVICES)+19:0] req_addr,
  input  wire logic [3:0]                 req_wdata,
  input  wire logic [3:0]                 req_mask,
  // user answer
  output logic                            rsp_valid,
  output logic [3:0]                      rsp_rdata,
  output logic                            init_done,
  // memory pins
  output logic [9:0]                      mem_addr,
  output logic                            ras_n,
  output logic [DEVICES-1:0]              cas_n,
  output logic                            we_n,
  output logic                            oe_n,
  input  wire logic [3:0]                 data_io_in,
  output logic [3:0]                      data_io_out,
  output logic                            data_io_oe
);
  import fpd_pkg::*;
  localparam int DW = (DEVICES > 1) ? $clog2(DEVICES) : 1;
  localparam int TW = 16;
  localparam int GW = 32;
  typedef struct packed {
    fpd_state_t  state;
    logic [TW-1:0] cnt;
    logic [GW-1:0] ras_cnt;
    logic [3:0]  init_left;
    logic        inited;
    logic        row_open;
    logic [9:0]  open_row;
    logic [DW-1:0] dev;
    fpd_op_t     op;
    logic [9:0]  col;
    logic [3:0]  wdata;
    logic [3:0]  mask;
    logic        ref_pending;
    logic [9:0]  addr;
    logic        ras_n;
    logic [DEVICES-1:0] cas_n;
    logic        we_n;
    logic        oe_n;
    logic [3:0]  dout;
    logic        dout_oe;
    logic [3:0]  rdata;
    logic        rsp;
  } fpd_ctrl_state_t;
  fpd_ctrl_state_t st, next_st;
  logic [3:0] din_meta, din_sync;
  logic       gap_load, gap_done;
  logic [DW-1:0] req_dev;
  // data pins come from off chip: two stages before use
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      din_meta <= 4'h0;
      din_sync <= 4'h0;
    end else if (clk_en) begin
      din_meta <= data_io_in;
      din_sync <= din_meta;
    end
  end
  assign req_dev = (DEVICES > 1) ? DW'(req_addr[$clog2(DEVICES)+19:20]) : '0;
  fpd_timer #(.WIDTH(GW)) u_refresh_gap (
    .clk_sys    (clk_sys),
    .rst_n      (rst_n),
    .clk_en     (clk_en),
    .load       (gap_load),
    .load_value (GW'(REFRESH_GAP)),
    .done       (gap_done)
  );
  assign gap_load = gap_done;
  assign req_ready = (st.state == FPD_IDLE) && st.inited && !st.ref_pending
                     && !(st.row_open && req_addr[19:10] != st.open_row);
  always_comb begin
    next_st = st;
    next_st.rsp = 1'b0;
    if (st.cnt != '0) next_st.cnt = st.cnt - 1'b1;
    if (st.ras_cnt != '0) next_st.ras_cnt = st.ras_cnt - 1'b1;
    if (gap_done) next_st.ref_pending = 1'b1;
    unique case (st.state)
      FPD_POWERUP: if (st.cnt == '0) begin
        next_st.state = FPD_PRE;
      end
      FPD_IDLE: begin
        if (st.ref_pending || !st.inited) begin
          if (st.row_open) begin // page closed before refresh
            next_st.state = FPD_RASUP;
          end else begin
            next_st.cas_n = '0; // column before row
            // cleared on entry so a tick during the refresh is not lost
            next_st.ref_pending = gap_done;
            next_st.we_n  = 1'b1;
            next_st.cnt   = TW'(`FPD_CAS_PRE_CYC);
            next_st.state = FPD_REFR;
          end
        end else if (req_valid && st.row_open && req_addr[19:10] != st.open_row) begin
          next_st.state = FPD_RASUP;
        end else if (req_valid) begin
          next_st.dev   = req_dev;
          next_st.op    = req_op;
          next_st.col   = req_addr[9:0];
          next_st.wdata = req_wdata;
          next_st.mask  = req_mask;
          if (st.row_open) begin
            next_st.addr  = req_addr[9:0];
            next_st.state = FPD_COL;
          end else begin
            next_st.addr     = req_addr[19:10];
            next_st.open_row = req_addr[19:10];
            next_st.state    = FPD_ROW;
          end
          if (req_op == FPD_OP_WRITE) begin
            next_st.we_n    = 1'b0; // early write
            next_st.oe_n    = 1'b1;
            next_st.dout    = req_wdata & req_mask | 4'h0;
            next_st.dout_oe = 1'b1;
          end
        end
      end
      FPD_ROW: begin
        next_st.ras_n    = 1'b0;
        next_st.row_open = 1'b1;
        next_st.ras_cnt  = GW'(`FPD_RC_CYC);
        next_st.cnt      = TW'(`FPD_ROW_HOLD_CYC);
        next_st.state    = FPD_COL;
      end
      FPD_COL: if (st.cnt == '0) begin
        if (st.addr != st.col) begin
          next_st.addr = st.col;
        end else begin
          next_st.cas_n[st.dev] = 1'b0;
          if (st.op != FPD_OP_WRITE) next_st.oe_n = 1'b0;
          next_st.cnt   = TW'(`FPD_ACCESS_CYC);
          if (st.op == FPD_OP_RMW) next_st.ras_cnt = GW'(`FPD_RMW_CYC);
          next_st.state = FPD_DATA;
        end
      end
      FPD_DATA: if (st.cnt == '0) begin
        if (st.op == FPD_OP_WRITE) begin
          next_st.state = FPD_CASUP;
        end else begin
          next_st.rdata = din_sync;
          next_st.rsp   = 1'b1;
          if (st.op == FPD_OP_RMW) begin
            next_st.oe_n    = 1'b1; // turn device outputs off first
            next_st.dout    = (st.wdata & st.mask) | (din_sync & ~st.mask);
            next_st.dout_oe = 1'b1;
            next_st.cnt     = TW'(`FPD_WE_CYC);
            next_st.state   = FPD_WRLATE;
          end else begin
            next_st.state = FPD_CASUP;
          end
        end
      end
      FPD_WRLATE: begin
        next_st.we_n = 1'b0; // later write strobe latches data
        if (st.cnt == '0) next_st.state = FPD_CASUP;
      end
      FPD_CASUP: begin
        next_st.cas_n   = '1;
        next_st.oe_n    = 1'b1;
        next_st.we_n    = 1'b1;
        next_st.dout_oe = 1'b0;
        next_st.cnt     = TW'(`FPD_CAS_PRE_CYC);
        next_st.state   = FPD_IDLE;
      end
      FPD_RASUP: if (st.ras_cnt == '0) begin
        next_st.ras_n    = 1'b1;
        next_st.row_open = 1'b0;
        next_st.cnt      = TW'(`FPD_PRE_CYC);
        next_st.state    = FPD_PRE;
      end
      FPD_PRE: if (st.cnt == '0) begin
        next_st.state = FPD_IDLE;
      end
      FPD_REFR: if (st.cnt == '0) begin
        if (st.ras_n) begin
          next_st.ras_n   = 1'b0;
          next_st.ras_cnt = GW'(`FPD_RC_CYC);
          next_st.cnt     = TW'(`FPD_CYC_MIN(`FPD_ROW_ACCESS_NS));
        end else begin
          next_st.ras_n       = 1'b1;
          next_st.cas_n       = '1;
          if (!st.inited) begin
            next_st.init_left = st.init_left - 4'h1;
            next_st.inited    = (st.init_left == 4'h1);
          end
          next_st.cnt   = TW'(`FPD_PRE_CYC);
          next_st.state = FPD_PRE;
        end
      end
      default: next_st.state = FPD_IDLE;
    endcase
  end
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      st           <= '0;
      st.state     <= FPD_POWERUP;
      st.cnt       <= TW'(POWERUP_CYC); // strobes held high meanwhile
      st.init_left <= 4'(`FPD_INIT_REFRESHES);
      st.ras_n     <= 1'b1;
      st.cas_n     <= '1;
      st.we_n      <= 1'b1;
      st.oe_n      <= 1'b1;
    end else if (clk_en) begin
      st <= next_st;
    end
  end
  assign mem_addr    = st.addr;
  assign ras_n       = st.ras_n;
  assign cas_n       = st.cas_n;
  assign we_n        = st.we_n;
  assign oe_n        = st.oe_n;
  assign data_io_out = st.dout;
  assign data_io_oe  = st.dout_oe;
  assign rsp_valid   = st.rsp;
  assign rsp_rdata   = st.rdata;
  assign init_done   = st.inited;
endmodule : fpd_ctrl

// ### sim/fpd_ctrl_monitor.sv
`timescale 1ns/1ps
module fpd_ctrl_monitor #(
  parameter int DEVICES     = 2,
  parameter int POWERUP_CYC = 20,
  parameter int REFRESH_GAP = 40
) (
  // clock and reset
  input wire logic               clk_sys,
  input wire logic               rst_n,
  // status and pins
  input wire logic               init_done,
  input wire logic [9:0]         mem_addr,
  input wire logic               ras_n,
  input wire logic [DEVICES-1:0] cas_n,
  input wire logic               we_n,
  input wire logic               oe_n,
  input wire logic               data_io_oe
);
  localparam int RC_CYC = 14;
  int   pu_cnt, gap_cnt, ref_cnt, n_cbr;
  logic ras_q;
  logic cbr;
  assign cbr = ras_q && !ras_n && !(&cas_n);
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      pu_cnt  <= 0;
      gap_cnt <= 1000;
      ref_cnt <= 0;
      n_cbr   <= 0;
      ras_q   <= 1'b1;
    end else begin
      ras_q   <= ras_n;
      pu_cnt  <= (pu_cnt < POWERUP_CYC) ? pu_cnt + 1 : pu_cnt;
      gap_cnt <= (ras_q && !ras_n) ? 1 : ((gap_cnt < 1000) ? gap_cnt + 1 : gap_cnt);
      ref_cnt <= cbr ? 0 : ref_cnt + 1;
      n_cbr   <= cbr ? n_cbr + 1 : n_cbr;
    end
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  property p_powerup_quiet; pu_cnt < POWERUP_CYC |-> ras_n && (&cas_n); endproperty
  a_powerup_quiet: assert property (p_powerup_quiet) else $error("strobe in wait");
  property p_init_count; $rose(init_done) |-> n_cbr >= 8; endproperty
  a_init_count: assert property (p_init_count) else $error("early init done");
  property p_row_addr; $fell(ras_n) && (&cas_n) |-> $stable(mem_addr) ##1 $stable(mem_addr);
  endproperty
  a_row_addr: assert property (p_row_addr) else $error("row address moved");
  property p_col_addr; $fell(&cas_n) && !ras_n |-> $stable(mem_addr); endproperty
  a_col_addr: assert property (p_col_addr) else $error("column address moved");
  property p_early_write; $fell(&cas_n) && !ras_n && !we_n |-> data_io_oe && oe_n; endproperty
  a_early_write: assert property (p_early_write) else $error("early write bad");
  property p_late_write; $fell(we_n) |-> data_io_oe; endproperty
  a_late_write: assert property (p_late_write) else $error("late write undriven");
  property p_no_fight; !oe_n |-> !data_io_oe && $onehot(~cas_n); endproperty
  a_no_fight: assert property (p_no_fight) else $error("read drive clash");
  property p_precharge; $rose(ras_n) |=> ras_n [*4]; endproperty
  a_precharge: assert property (p_precharge) else $error("short precharge");
  property p_cycle_gap; ras_q && !ras_n |-> gap_cnt >= RC_CYC; endproperty
  a_cycle_gap: assert property (p_cycle_gap) else $error("cycle too short");
  property p_refresh_due; init_done |-> ref_cnt <= 2 * REFRESH_GAP; endproperty
  a_refresh_due: assert property (p_refresh_due) else $error("refresh late");
endmodule : fpd_ctrl_monitor

// ### sim/fpd_dram_model.sv
`timescale 1ns/1ps
module fpd_dram_model (
  // strobes
  input  wire logic       ras_n,
  input  wire logic       cas_n,
  input  wire logic       we_n,
  input  wire logic       oe_n,
  // address and data line
  input  wire logic [9:0] addr,
  input  wire logic [3:0] bus,
  output logic      [3:0] dq,
  output logic            dq_oe
);
  logic [3:0]  mem [bit [19:0]];
  logic [9:0]  row;
  logic [19:0] loc;
  logic [3:0]  last = 4'h0;
  logic        early = 1'b0;
  logic        valid = 1'b0;
  int          acc_ns = 15;
  int          n_cbr = 0;
  int          n_open = 0;
  always @(negedge ras_n) begin
    if (cas_n) begin
      row = addr;
      n_open++;
    end else begin
      n_cbr++;
    end
  end
  always @(negedge cas_n) begin
    if (!ras_n) begin
      loc = {row, addr};
      early = !we_n;
      if (!we_n) mem[loc] = bus;
    end
  end
  always @(negedge we_n) begin
    if (!ras_n && !cas_n) mem[loc] = bus;
  end
  // data only an access time after the column strobe
  always @(negedge cas_n) begin
    valid = 1'b0;
    #(acc_ns);
    valid = !cas_n;
  end
  always @(posedge cas_n) valid = 1'b0;
  assign dq_oe = !ras_n && !cas_n && !oe_n && we_n && !early && valid;
  // released line shows the inverse, so a late sample cannot pass by luck
  always @* begin
    if (dq_oe) begin
      dq = mem.exists(loc) ? mem[loc] : 4'h0;
      last = dq;
    end else begin
      dq = ~last;
    end
  end
endmodule : fpd_dram_model

// ### sim/fpd_ctrl_tb.sv
`timescale 1ns/1ps
module fpd_ctrl_tb;
  import fpd_pkg::*;
  logic        clk_sys, rst_n, clk_en, req_valid, req_ready, rsp_valid, init_done;
  fpd_op_t     req_op;
  logic [20:0] req_addr;
  logic [3:0]  req_wdata, req_mask, rsp_rdata, data_io_in, data_io_out;
  logic [9:0]  mem_addr;
  logic        ras_n, we_n, oe_n, data_io_oe;
  logic [1:0]  cas_n;
  wire  [1:0]  dev_oe;
  wire  [7:0]  dev_dq;
  logic [3:0]  ref_mem [bit [20:0]];
  logic [31:0] rnd = 32'hc083fda6;
  int          n_fail = 0;
  int          n_compared = 0;
  int          i, k, c0, o0;
  assign data_io_in = data_io_oe ? data_io_out : (dev_oe[1] ? dev_dq[7:4] : dev_dq[3:0]);
  fpd_ctrl #(.POWERUP_CYC(20), .REFRESH_GAP(40)) fpd_ctrl_i (.clk_sys(clk_sys),
    .rst_n(rst_n), .clk_en(clk_en), .req_valid(req_valid), .req_ready(req_ready),
    .req_op(req_op), .req_addr(req_addr), .req_wdata(req_wdata), .req_mask(req_mask),
    .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .init_done(init_done),
    .mem_addr(mem_addr), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .oe_n(oe_n),
    .data_io_in(data_io_in), .data_io_out(data_io_out), .data_io_oe(data_io_oe));
  fpd_dram_model fpd_dram_model_i [1:0] (.ras_n(ras_n), .cas_n(cas_n), .we_n(we_n),
    .oe_n(oe_n), .addr(mem_addr), .bus(data_io_in), .dq(dev_dq), .dq_oe(dev_oe));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  function automatic logic [3:0] exp_rd(input logic [20:0] a);
    return ref_mem.exists(a) ? ref_mem[a] : 4'h0;
  endfunction : exp_rd
  task automatic check(input logic [3:0] seen, input logic [3:0] want);
    n_compared++;
    if (seen !== want) begin
      n_fail++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask : check
  task automatic wrap_up;
    if (n_fail == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : wrap_up
  task automatic access(input fpd_op_t op, input logic [20:0] a, input logic [3:0] d, m);
    logic [3:0] old;
    int         n;
    old = exp_rd(a);
    @(posedge clk_sys);
    #1;
    req_op = op;
    req_addr = a;
    req_wdata = d;
    req_mask = m;
    req_valid = 1'b1;
    n = 0;
    // ready is looked at mid-cycle, where it stands until the taking edge
    @(negedge clk_sys);
    while (req_ready !== 1'b1 && n < 2000) begin
      @(negedge clk_sys);
      n++;
    end
    check({3'h0, req_ready}, 4'h1);
    @(posedge clk_sys);
    #1 req_valid = 1'b0;
    if (op == FPD_OP_WRITE) ref_mem[a] = d & m;
    else begin
      if (op == FPD_OP_RMW) ref_mem[a] = (old & ~m) | (d & m);
      n = 0;
      do begin @(negedge clk_sys); n++; end while (rsp_valid !== 1'b1 && n < 100);
      check({3'h0, rsp_valid}, 4'h1);
      check(rsp_rdata, old);
    end
  endtask : access
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  initial begin
    #300000;
    n_fail++;
    wrap_up;
  end
  initial begin
    rst_n = 1'b0;
    clk_en = 1'b1;
    req_valid = 1'b0;
    req_op = FPD_OP_READ;
    req_addr = '0;
    req_wdata = '0;
    req_mask = '0;
    repeat (8) @(posedge clk_sys);
    #1 rst_n = 1'b1;
    k = 0;
    while (init_done !== 1'b1 && k < 2000) begin
      @(posedge clk_sys);
      k++;
    end
    check({3'h0, init_done}, 4'h1);
    check({3'h0, (fpd_dram_model_i[0].n_cbr >= 8)}, 4'h1);
    access(FPD_OP_WRITE, {1'b0, 20'h0}, 4'ha, 4'hf);
    access(FPD_OP_WRITE, {1'b1, 20'h0}, 4'h5, 4'hf);
    access(FPD_OP_WRITE, {1'b0, 20'hfffff}, 4'hc, 4'hf);
    access(FPD_OP_RMW, {1'b0, 20'hfffff}, 4'h3, 4'h3);
    o0 = fpd_dram_model_i[0].n_open;
    c0 = fpd_dram_model_i[0].n_cbr;
    access(FPD_OP_READ, {1'b0, 20'hffc00}, 4'h0, 4'h0);
    access(FPD_OP_READ, {1'b0, 20'hfffff}, 4'h0, 4'h0);
    k = (fpd_dram_model_i[0].n_open - o0) <= (fpd_dram_model_i[0].n_cbr - c0);
    check(k[3:0], 4'h1);
    access(FPD_OP_READ, {1'b0, 20'h0}, 4'h0, 4'h0);
    access(FPD_OP_READ, {1'b1, 20'h0}, 4'h0, 4'h0);
    for (i = 0; i < 200; i++) begin
      rnd = lfsr(rnd);
      if (i == 100) begin
        fpd_dram_model_i[0].acc_ns = 60;
        fpd_dram_model_i[1].acc_ns = 60;
      end
      access(rnd[31:30] == 2'h3 ? FPD_OP_READ : fpd_op_t'(rnd[31:30]),
        {rnd[29], 8'h00, rnd[28:27], rnd[9:0]}, rnd[13:10], rnd[17:14]);
    end
    c0 = fpd_dram_model_i[0].n_cbr;
    repeat (400) @(posedge clk_sys);
    check({3'h0, (fpd_dram_model_i[0].n_cbr - c0 >= 5)}, 4'h1);
    wrap_up;
  end
endmodule : fpd_ctrl_tb
bind fpd_ctrl fpd_ctrl_monitor #(.DEVICES(DEVICES), .POWERUP_CYC(POWERUP_CYC),
  .REFRESH_GAP(REFRESH_GAP)) fpd_ctrl_monitor_i (.clk_sys(clk_sys), .rst_n(rst_n),
  .init_done(init_done), .mem_addr(mem_addr), .ras_n(ras_n), .cas_n(cas_n),
  .we_n(we_n), .oe_n(oe_n), .data_io_oe(data_io_oe));
